// file: design/arc_pkg.sv
// Package with the register map, field layout and timing of the reference/sequencer/autocycle bank
package arc_pkg;
  // Register offsets on the configuration port
  localparam logic [11:0] REF_SETUP_ADDR = 12'h021;
  localparam logic [11:0] SEQUENCE_ADDR = 12'h022;
  localparam logic [11:0] AUTO_CTRL_ADDR = 12'h023;
  // Reset values
  localparam logic [7:0] REF_SETUP_RST = 8'h12;
  localparam logic [7:0] SEQUENCE_RST = 8'h80;
  localparam logic [7:0] AUTO_CTRL_RST = 8'h00;
  // Writable bits; everything else reads zero
  localparam logic [7:0] REF_SETUP_MASK = 8'h9E;
  localparam logic [7:0] SEQUENCE_MASK = 8'hFF;
  localparam logic [7:0] AUTO_CTRL_MASK = 8'h0F;
  // Field positions
  localparam int CLAMP_SEL_BIT = 7;
  localparam int RANGE_LSB = 2;
  localparam int RANGE_W = 3;
  localparam int HIZ_BIT = 1;
  localparam int STD_SEQ_BIT = 7;
  localparam int SLOT_W = 7;
  localparam int PCODE_LSB = 1;
  localparam int PCODE_W = 3;
  localparam int AUTO_EN_BIT = 0;
  // Autocycle periods in microseconds, indexed by period code
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned AC_PERIOD_US [8] = '{10, 20, 40, 80, 100, 200, 400, 800};
  // Cycles per period at the system clock rate
  function automatic int unsigned us_to_cyc(input int unsigned us);
    return (us * 1000000) / CLK_PERIOD_PS;
  endfunction
endpackage

// file: design/arc_regs.sv
// Reference, sequencer and autocycle control registers with the autocycle convert-start timer
`timescale 1ns/10ps
module arc_regs #(
  parameter int unsigned AC_PERIOD_CYC [8] = '{
    arc_pkg::us_to_cyc(arc_pkg::AC_PERIOD_US[0]), arc_pkg::us_to_cyc(arc_pkg::AC_PERIOD_US[1]),
    arc_pkg::us_to_cyc(arc_pkg::AC_PERIOD_US[2]), arc_pkg::us_to_cyc(arc_pkg::AC_PERIOD_US[3]),
    arc_pkg::us_to_cyc(arc_pkg::AC_PERIOD_US[4]), arc_pkg::us_to_cyc(arc_pkg::AC_PERIOD_US[5]),
    arc_pkg::us_to_cyc(arc_pkg::AC_PERIOD_US[6]), arc_pkg::us_to_cyc(arc_pkg::AC_PERIOD_US[7])},
  parameter int CNT_W = 17
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic config_mode_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic clamp_current_reduce_select_out,
  output logic [2:0] reference_range_out,
  output logic reference_high_z_enable_out,
  output logic standard_sequencer_enable_out,
  output logic [6:0] advanced_slot_count_out,
  output logic [7:0] advanced_slot_total_out,
  output logic advanced_sequencer_active_out,
  output logic [2:0] autocycle_period_code_out,
  output logic autocycle_enable_out,
  output logic convert_start_out
);

  // Refuse periods the counter cannot hold
  generate
    for (genvar g = 0; g < 8; g++) begin : g_chk
      if (AC_PERIOD_CYC[g] < 1 || AC_PERIOD_CYC[g] > (2 ** CNT_W)) begin : g_bad
        $error("autocycle period does not fit the counter");
      end
    end
  endgenerate

  logic [7:0] ref_r, ref_nxt, seq_r, seq_nxt, ac_r, ac_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic adv_r, adv_nxt;
  logic [7:0] total_r, total_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic start_r, start_nxt;
  logic wr_ok, ac_wr;
  logic [CNT_W-1:0] last_cnt;

  assign wr_ok = wr_en_in && config_mode_in;
  assign ac_wr = wr_ok && (addr_in == arc_pkg::AUTO_CTRL_ADDR);

  // Register writes, reserved bits masked off, and read mux
  always_comb begin
    ref_nxt = ref_r;
    seq_nxt = seq_r;
    ac_nxt = ac_r;
    if (wr_ok) begin
      unique case (addr_in)
        arc_pkg::REF_SETUP_ADDR: begin
          ref_nxt = wr_data_in & arc_pkg::REF_SETUP_MASK;
        end
        arc_pkg::SEQUENCE_ADDR: seq_nxt = wr_data_in & arc_pkg::SEQUENCE_MASK;
        arc_pkg::AUTO_CTRL_ADDR: ac_nxt = wr_data_in & arc_pkg::AUTO_CTRL_MASK;
        default: ;
      endcase
    end
    rd_valid_nxt = rd_en_in;
    rd_data_nxt = 8'h00; // Unmapped offsets read zero
    if (rd_en_in) begin
      unique case (addr_in)
        arc_pkg::REF_SETUP_ADDR: rd_data_nxt = ref_r;
        arc_pkg::SEQUENCE_ADDR: rd_data_nxt = seq_r;
        arc_pkg::AUTO_CTRL_ADDR: rd_data_nxt = ac_r;
        default: rd_data_nxt = 8'h00;
      endcase
    end
    // Advanced sequencer state derived from the new sequencer value
    adv_nxt = !seq_nxt[arc_pkg::STD_SEQ_BIT] && (seq_nxt[arc_pkg::SLOT_W-1:0] != 7'h00);
    total_nxt = {1'b0, seq_nxt[arc_pkg::SLOT_W-1:0]} + 8'h01;
  end

  // Register storage
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ref_r <= arc_pkg::REF_SETUP_RST;
      seq_r <= arc_pkg::SEQUENCE_RST;
      ac_r <= arc_pkg::AUTO_CTRL_RST;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
      adv_r <= 1'b0;
      total_r <= 8'h01;
    end else begin
      ref_r <= ref_nxt;
      seq_r <= seq_nxt;
      ac_r <= ac_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      adv_r <= adv_nxt;
      total_r <= total_nxt;
    end
  end

  // Autocycle timer; any write to its register restarts the period
  always_comb begin
    last_cnt = CNT_W'(AC_PERIOD_CYC[ac_nxt[arc_pkg::PCODE_LSB +: arc_pkg::PCODE_W]] - 1);
    start_nxt = 1'b0;
    if (!ac_nxt[arc_pkg::AUTO_EN_BIT] || ac_wr) begin
      cnt_nxt = '0;
    end else if (cnt_r >= last_cnt) begin
      cnt_nxt = '0;
      start_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  // Timer storage
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r <= '0;
      start_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      start_r <= start_nxt;
    end
  end

  // Field outputs straight from the registers
  assign clamp_current_reduce_select_out = ref_r[arc_pkg::CLAMP_SEL_BIT];
  assign reference_range_out = ref_r[arc_pkg::RANGE_LSB +: arc_pkg::RANGE_W];
  assign reference_high_z_enable_out = ref_r[arc_pkg::HIZ_BIT];
  assign standard_sequencer_enable_out = seq_r[arc_pkg::STD_SEQ_BIT];
  assign advanced_slot_count_out = seq_r[arc_pkg::SLOT_W-1:0];
  assign advanced_slot_total_out = total_r;
  assign advanced_sequencer_active_out = adv_r;
  assign autocycle_period_code_out = ac_r[arc_pkg::PCODE_LSB +: arc_pkg::PCODE_W];
  assign autocycle_enable_out = ac_r[arc_pkg::AUTO_EN_BIT];
  assign convert_start_out = start_r;
  assign rd_data_out = rd_data_r;
  assign rd_valid_out = rd_valid_r;

  // Helper: cycles since last start, valid only across an undisturbed period
  logic [CNT_W:0] gap_r;
  logic gap_ok_r;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gap_r <= '0;
      gap_ok_r <= 1'b0;
    end else begin
      gap_r <= start_r ? (CNT_W+1)'(1) : gap_r + (CNT_W+1)'(1);
      gap_ok_r <= ac_wr ? 1'b0 : (start_r ? 1'b1 : gap_ok_r);
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  // Field checks: each write shows on its outputs one cycle later
  a_reset_values: assert property ($rose(resetn_in) |->
    ref_r == arc_pkg::REF_SETUP_RST && seq_r == arc_pkg::SEQUENCE_RST)
    else $error("reset values wrong");
  a_clamp_select: assert property (wr_ok && addr_in == arc_pkg::REF_SETUP_ADDR |=>
    clamp_current_reduce_select_out == $past(wr_data_in[arc_pkg::CLAMP_SEL_BIT]))
    else $error("clamp select not written");
  a_range_field: assert property (wr_ok && addr_in == arc_pkg::REF_SETUP_ADDR |=>
    reference_range_out == $past(wr_data_in[arc_pkg::RANGE_LSB +: arc_pkg::RANGE_W]))
    else $error("range field not written");
  a_high_z: assert property (wr_ok && addr_in == arc_pkg::REF_SETUP_ADDR |=>
    reference_high_z_enable_out == $past(wr_data_in[arc_pkg::HIZ_BIT]))
    else $error("high-Z bit not written");
  a_std_seq: assert property (wr_ok && addr_in == arc_pkg::SEQUENCE_ADDR |=>
    standard_sequencer_enable_out == $past(wr_data_in[arc_pkg::STD_SEQ_BIT]))
    else $error("standard sequencer bit not written");
  a_slot_field: assert property (wr_ok && addr_in == arc_pkg::SEQUENCE_ADDR |=>
    advanced_slot_count_out == $past(wr_data_in[arc_pkg::SLOT_W-1:0]))
    else $error("slot field not written");
  a_slot_total: assert property (advanced_sequencer_active_out |->
    advanced_slot_total_out == advanced_slot_count_out + 8'h01)
    else $error("slot total not count plus one");
  a_adv_active: assert property (advanced_sequencer_active_out ==
    (!standard_sequencer_enable_out && advanced_slot_count_out != 7'h00))
    else $error("advanced active wrong");
  a_reserved_zero: assert property (rd_en_in && addr_in == arc_pkg::AUTO_CTRL_ADDR |=>
    rd_data_out[7:4] == 4'h0)
    else $error("reserved bits not zero");
  a_ref_reserved: assert property (rd_en_in && addr_in == arc_pkg::REF_SETUP_ADDR |=>
    rd_data_out[6:5] == 2'b00 && !rd_data_out[0])
    else $error("reference reserved bits not zero");
  a_ac_fields: assert property (wr_ok && addr_in == arc_pkg::AUTO_CTRL_ADDR |=>
    autocycle_enable_out == $past(wr_data_in[arc_pkg::AUTO_EN_BIT]))
    else $error("autocycle enable not written");
  a_ac_period: assert property (convert_start_out && gap_ok_r |->
    gap_r == (CNT_W+1)'(AC_PERIOD_CYC[autocycle_period_code_out]))
    else $error("autocycle period wrong");
  a_ac_off: assert property (!autocycle_enable_out |-> !convert_start_out)
    else $error("start while autocycle off");
  a_read_answer: assert property (rd_en_in |=> rd_valid_out)
    else $error("read answer missing");
  a_no_cfg_write: assert property (
    wr_en_in && !config_mode_in |=> $stable(ref_r) && $stable(seq_r) && $stable(ac_r))
    else $error("write outside configuration mode");

  // Main scenarios: periodic starts, advanced mode, reads, timer restarts
  c_start_pulse: cover property (convert_start_out ##[1:1000] convert_start_out);
  c_adv_on: cover property ($rose(advanced_sequencer_active_out));
  c_ref_read: cover property (rd_en_in && addr_in == 12'h021);
  c_ac_restart: cover property (autocycle_enable_out && ac_wr);

endmodule

// file: tb/arc_host.sv
// Host controller model driving the register port of the bank
`timescale 1ns/10ps
module arc_host (
  input wire logic clk_in,
  output logic wr_out,
  output logic rd_out,
  output logic [11:0] addr_out,
  output logic [7:0] data_out
);
  // Idle port: strobes low, address and data scrambled
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 12'hFFF;
    data_out = 8'h5A;
  end
  // One access, held across the taking edge, then released
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_out = w;
    rd_out = !w;
    addr_out = a;
    // Writes to offset 12'h020 never set bit 1; setup writes to 12'h021 pass unchanged
    data_out = (w && a == 12'h020) ? (d & 8'hFD) : d;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
    data_out = ~d;
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the reference, sequencer and autocycle bank
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module testbench;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cfg = 1'b1;
  logic wr, rd, rv, cs, cl, hz, se, adv, ae;
  logic [11:0] ad;
  logic [7:0] wd, rdat, tot, d, ref_e;
  logic [2:0] rg, pc;
  logic [6:0] sl;
  logic [7:0] exp_q[$];
  logic [7:0] exp_b;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int k;
  logic [31:0] seed = 32'h385D13BD;
  always #5 sys_clk_in = ~sys_clk_in;
  arc_host u_host (.clk_in(sys_clk_in), .wr_out(wr), .rd_out(rd), .addr_out(ad), .data_out(wd));
  arc_regs #(.AC_PERIOD_CYC('{2, 3, 4, 5, 6, 7, 8, 9})) u_arc_regs (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .config_mode_in(cfg),
    .wr_en_in(wr), .rd_en_in(rd), .addr_in(ad), .wr_data_in(wd),
    .rd_data_out(rdat), .rd_valid_out(rv), .clamp_current_reduce_select_out(cl),
    .reference_range_out(rg), .reference_high_z_enable_out(hz),
    .standard_sequencer_enable_out(se), .advanced_slot_count_out(sl),
    .advanced_slot_total_out(tot), .advanced_sequencer_active_out(adv),
    .autocycle_period_code_out(pc), .autocycle_enable_out(ae), .convert_start_out(cs));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Queue the expected byte, then read
  task automatic rdq(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.acc(1'b0, a, 8'h00);
  endtask
  // Sequencer write with field checks
  task automatic seqw(input logic [7:0] v);
    u_host.acc(1'b1, 12'h022, v);
    `CHK({se, sl, tot, adv}, {v, {1'b0, v[6:0]} + 8'h01, !v[7] && v[6:0] != 0})
  endtask
  // Cycles until the next convert start, capped at 99
  task automatic gap(output int n);
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (cs !== 1'b1 && n < 99);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Read answers are matched against the oldest note
  always @(negedge sys_clk_in) begin
    if (rv === 1'b1) begin
      `CHK(exp_q.size() != 0, 1'b1)
      if (exp_q.size() != 0) begin
        exp_b = exp_q.pop_front();
        `CHK(rdat, exp_b)
      end
    end
  end
  // Hang guard
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(negedge sys_clk_in);
    resetn_in = 1'b1;
    `CHK({cl, rg, hz, se, tot, adv, ae}, {5'b01001, 1'b1, 8'h01, 2'b00})
    rdq(12'h021, 8'h12);
    rdq(12'h022, 8'h80);
    rdq(12'h023, 8'h00);
    rdq(12'h020, 8'h00);
    $display("reset test done");
    repeat (8) begin
      seed = lfsr(seed);
      d = seed[7:0];
      d[4:2] = 3'(seed[10:8] % 3'd5);
      u_host.acc(1'b1, 12'h021, d);
      ref_e = d & 8'h9E;
      `CHK({cl, rg, hz}, {d[7], d[4:1]})
      rdq(12'h021, ref_e);
      seqw(seed[31:24]);
    end
    seqw(8'h7F);
    seqw(8'h00);
    cfg = 1'b0;
    u_host.acc(1'b1, 12'h021, 8'hFF);
    cfg = 1'b1;
    u_host.acc(1'b1, 12'h030, 8'hFF);
    rdq(12'h021, ref_e);
    $display("register test done");
    for (int c = 0; c < 8; c++) begin
      u_host.acc(1'b1, 12'h023, {4'hF, 3'(c), 1'b1});
      `CHK({pc, ae}, {3'(c), 1'b1})
      rdq(12'h023, {4'h0, 3'(c), 1'b1});
      gap(k);
      gap(k);
      `CHK(k, c + 2)
    end
    u_host.acc(1'b1, 12'h023, 8'h00);
    gap(k);
    `CHK(k, 99)
    $display("autocycle test done");
    `CHK(exp_q.size(), 0)
    end_of_test();
  end
endmodule
